// ==== rtl/dma_term_chan.sv ====
// one channel's transfer sequencer and termination logic
`timescale 1ns/1ps
`default_nettype none
`include "dma_term_map.svh"
module dma_term_chan #(
  parameter int CW = 16
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_nrst,
  input  wire logic          i_run,
  input  wire logic          i_start,
  input  wire logic          i_burst,
  input  wire logic          i_level,
  input  wire logic          i_dual,
  input  wire logic          i_req,
  input  wire logic          i_req_edge,
  input  wire logic          i_load,
  input  wire logic [CW-1:0] i_load_val,
  input  wire logic          i_bus_done,
  output logic               o_bus_read,
  output logic               o_bus_write,
  output logic               o_ack,
  output logic               o_busy,
  output logic               o_count_end,
  output logic [CW-1:0]      o_count
);
  import dma_term_pkg::*;
  ch_state_t state;
  phase_t    phase;
  logic      pend;
  logic      take;
  logic      boundary;
  logic      last;
  logic      armed;

  // a request is taken only while running; burst-edge keeps one latched start
  // at a boundary the finishing transfer still owns one count: never take past the last
  assign take = (state == CH_RUN) && i_run &&
                (i_burst && !i_level ? (armed || i_req_edge) : i_req) &&
                ((phase != PH_NONE) ? !last : (o_count != '0));
  assign boundary = (phase == PH_NONE) ||
                    (i_bus_done && (phase == PH_WRITE || (phase == PH_READ && !i_dual)));
  assign last = (o_count == {{(CW-1){1'b0}}, 1'b1});

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= CH_IDLE;
    end else begin
      case (state)
        CH_IDLE: if (i_start) begin
          state <= CH_RUN;
        end
        // clear of run enable: stop accepting, drain what was taken
        CH_RUN: if (!i_run) begin
          state <= CH_DRAIN;
        end else if (o_count == '0 && phase == PH_NONE && !pend) begin
          state <= CH_IDLE;
        end
        CH_DRAIN: if (!pend && phase == PH_NONE) begin
          state <= CH_IDLE;
        end
        default: state <= CH_IDLE;
      endcase
    end
  end

  // burst-edge: one request edge starts the burst, run is then sampled every cycle
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      armed <= 1'b0;
    end else if (state != CH_RUN) begin
      armed <= 1'b0;
    end else if (i_req_edge) begin
      armed <= 1'b1;
    end
  end

  // one pending accepted request; level and edge treated alike
  // burst-edge samples the stop every cycle once armed, not only at each request instant
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      pend  <= 1'b0;
      o_ack <= 1'b0;
    end else begin
      o_ack <= 1'b0;
      if (take && !pend && (phase == PH_NONE || boundary)) begin
        pend  <= 1'b1;
        o_ack <= 1'b1;
      end else if (pend && phase == PH_NONE) begin
        pend <= 1'b0;
      end
    end
  end

  // phases only end on bus done; read is followed by its write only in dual mode
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      phase <= PH_NONE;
    end else begin
      case (phase)
        PH_NONE: if (pend) begin
          phase <= PH_READ;
        end
        PH_READ: if (i_bus_done) begin
          phase <= i_dual ? PH_WRITE : PH_NONE;
        end
        PH_WRITE: if (i_bus_done) begin
          phase <= PH_NONE;
        end
        default: phase <= PH_NONE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_count     <= '0;
      o_count_end <= 1'b0;
    end else begin
      o_count_end <= 1'b0;
      if (i_load && state == CH_IDLE) begin
        o_count <= i_load_val;
      end else if (boundary && phase != PH_NONE) begin
        o_count <= o_count - {{(CW-1){1'b0}}, 1'b1};
        o_count_end <= last;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bus_read  <= 1'b0;
      o_bus_write <= 1'b0;
      o_busy      <= 1'b0;
    end else begin
      o_bus_read  <= (phase == PH_NONE && pend) || (phase == PH_READ && !i_bus_done);
      o_bus_write <= (phase == PH_READ && i_bus_done && i_dual) ||
                     (phase == PH_WRITE && !i_bus_done);
      o_busy      <= (state != CH_IDLE);
    end
  end

  a_idle_no_ack: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state == CH_IDLE) |=> !o_ack)
    else $error("ack while idle");
  a_read_then_wr: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (phase == PH_READ && i_bus_done && i_dual) |=> (phase == PH_WRITE))
    else $error("dual read not followed by write");
  a_drain_no_ack: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state == CH_DRAIN) |-> !o_ack)
    else $error("request accepted while draining");
  a_count_cover: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (phase != PH_NONE) |-> (o_count != '0))
    else $error("transfer in flight beyond the count");
endmodule
`default_nettype wire

// ==== rtl/dma_term_map.svh ====
// register map, field positions and constants for the dma channel termination block
`ifndef DMA_TERM_MAP_SVH
`define DMA_TERM_MAP_SVH
`define OFF_CH0_CTRL   8'h00
`define OFF_CH1_CTRL   8'h04
`define OFF_CH0_COUNT  8'h08
`define OFF_CH1_COUNT  8'h0c
`define OFF_IRQ_STAT   8'h10
`define OFF_IRQ_CLR    8'h14
`define OFF_IRQ_EN     8'h18
`define BIT_RUN        0
`define BIT_TEND       1
`define BIT_IRQEN      2
`define BIT_BURST      5
`define BIT_LEVEL      6
`define BIT_DUAL       7
`define BIT_BUSY       8
`define CTRL_RESET     32'h0000_0000
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10
`endif

// ==== rtl/dma_term_pkg.sv ====
// types for the dma channel termination block
package dma_term_pkg;
  typedef enum logic [1:0] {
    CH_IDLE,
    CH_RUN,
    CH_DRAIN
  } ch_state_t;
  typedef enum logic [1:0] {
    PH_NONE,
    PH_READ,
    PH_WRITE
  } phase_t;
endpackage

// ==== rtl/dma_term_top.sv ====
// two-channel dma termination block with axi4-lite register slave
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dma_term_map.svh"
module dma_term_top #(
  parameter int CW = 16
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic [1:0]  i_dreq,
  input  wire logic [1:0]  i_bus_done,
  output logic [1:0]       o_bus_read,
  output logic [1:0]       o_bus_write,
  output logic [1:0]       o_dack,
  output logic             o_irq
);
  import dma_term_pkg::*;
  initial begin
    if (CW < 2 || CW > 32) $error("count width out of range");
  end

  logic [31:0]   ctrl [2];
  logic [1:0]    stat;
  logic [1:0]    irq_en;
  logic [1:0]    req_s1, req_s2, req_s3;
  logic [1:0]    busy, cend, start, load;
  logic [CW-1:0] count [2];
  logic [7:0]    aw_a;
  logic [31:0]   w_d;
  logic [3:0]    w_s;
  logic          aw_h, w_h, wr_go;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      req_s1 <= '0;
      req_s2 <= '0;
      req_s3 <= '0;
    end else begin
      req_s1 <= i_dreq;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // write channel: address and data may arrive in either order
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_h      <= 1'b0;
      w_h       <= 1'b0;
      aw_a      <= '0;
      w_d       <= '0;
      w_s       <= '0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `RESP_OKAY;
    end else begin
      o_awready <= !aw_h && !o_awready && !o_bvalid && i_awvalid;
      o_wready  <= !w_h && !o_wready && !o_bvalid && i_wvalid;
      if (o_awready && i_awvalid) begin
        aw_h <= 1'b1;
        aw_a <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        w_h <= 1'b1;
        w_d <= i_wdata;
        w_s <= i_wstrb;
      end
      if (wr_go) begin
        aw_h     <= 1'b0;
        w_h      <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= (aw_a <= `OFF_IRQ_EN && aw_a[1:0] == 2'b00) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end
  assign wr_go = aw_h && w_h && !o_bvalid;

  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      logic [7:0] off_ctl;
      logic [7:0] off_cnt;
      assign off_ctl = c ? `OFF_CH1_CTRL : `OFF_CH0_CTRL;
      assign off_cnt = c ? `OFF_CH1_COUNT : `OFF_CH0_COUNT;
      assign start[c] = wr_go && aw_a == off_ctl && w_s[0] && w_d[`BIT_RUN] &&
                        !ctrl[c][`BIT_RUN] && !busy[c];
      assign load[c] = wr_go && aw_a == off_cnt;

      // end flag set by hardware wins over software clear
      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
          ctrl[c] <= `CTRL_RESET;
        end else begin
          if (wr_go && aw_a == off_ctl) begin
            ctrl[c] <= merge(ctrl[c], w_d, w_s) & 32'h0000_00e5;
            ctrl[c][`BIT_TEND] <= ctrl[c][`BIT_TEND] & w_d[`BIT_TEND];
          end
          if (cend[c]) begin
            ctrl[c][`BIT_TEND] <= 1'b1;
            ctrl[c][`BIT_RUN]  <= 1'b0;
          end
        end
      end

      dma_term_chan #(.CW(CW)) u_chan (
        .i_clk_sys  (i_clk_sys),
        .i_nrst     (i_nrst),
        .i_run      (ctrl[c][`BIT_RUN]), // software clear halts, flag untouched
        .i_start    (start[c]),
        .i_burst    (ctrl[c][`BIT_BURST]),
        .i_level    (ctrl[c][`BIT_LEVEL]),
        .i_dual     (ctrl[c][`BIT_DUAL]),
        .i_req      (ctrl[c][`BIT_LEVEL] ? req_s2[c] : (req_s2[c] & ~req_s3[c])),
        .i_req_edge (req_s2[c] & ~req_s3[c]),
        .i_load     (load[c]),
        .i_load_val (w_d[CW-1:0]),
        .i_bus_done (i_bus_done[c]),
        .o_bus_read (o_bus_read[c]),
        .o_bus_write(o_bus_write[c]),
        .o_ack      (o_dack[c]),
        .o_busy     (busy[c]),
        .o_count_end(cend[c]),
        .o_count    (count[c])
      );

      a_halt_no_flag: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        ($fell(ctrl[c][`BIT_RUN]) && !$past(cend[c])) |-> !$rose(ctrl[c][`BIT_TEND]))
        else $error("software halt set end flag");
      a_end_sets_flag: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        cend[c] |=> ctrl[c][`BIT_TEND] && !ctrl[c][`BIT_RUN])
        else $error("count end did not set flag");
    end
  endgenerate

  // sticky end status, set wins over clear
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      stat   <= '0;
      irq_en <= '0;
    end else begin
      if (wr_go && aw_a == `OFF_IRQ_EN) begin
        irq_en <= w_d[1:0];
      end
      for (int c = 0; c < 2; c++) begin
        if (wr_go && aw_a == `OFF_IRQ_CLR && w_d[c]) stat[c] <= 1'b0;
        if (cend[c]) stat[c] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(stat & irq_en & {ctrl[1][`BIT_IRQEN], ctrl[0][`BIT_IRQEN]});
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= `RESP_OKAY;
    end else begin
      o_arready <= !o_arready && !o_rvalid && i_arvalid;
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rresp  <= `RESP_OKAY;
        case (i_araddr)
          `OFF_CH0_CTRL:  o_rdata <= ctrl[0] | {23'h0, busy[0], 8'h00};
          `OFF_CH1_CTRL:  o_rdata <= ctrl[1] | {23'h0, busy[1], 8'h00};
          `OFF_CH0_COUNT: o_rdata <= 32'(count[0]);
          `OFF_CH1_COUNT: o_rdata <= 32'(count[1]);
          `OFF_IRQ_STAT:  o_rdata <= {30'h0, stat};
          `OFF_IRQ_CLR:   o_rdata <= 32'h0000_0000;
          `OFF_IRQ_EN:    o_rdata <= {30'h0, irq_en};
          default: begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  a_irq_gated: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (stat == 2'b00) |=> !o_irq)
    else $error("irq without status");
endmodule
`default_nettype wire

// ==== verification/dma_channel_transfer_termination_tb.sv ====
// self-checking bench for the two-channel dma termination block
`timescale 1ns/1ps
`default_nettype none
`include "dma_term_map.svh"
module dma_channel_transfer_termination_tb;
  logic        clk = 0, nrst = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, rdat;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, resp, dreq = 0, done, bus_rd, bus_wr, dack;
  logic [1:0]  req_mode = 0, ch_sel = 0;
  logic [3:0]  tick = 0;
  int          num_errors = 0, n_tests = 0;
  int          nrd [2], nwr [2], ndack [2] = '{0, 0};

  dma_term_top #(.CW(16)) dma_term_top_i (.i_clk_sys(clk), .i_nrst(nrst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_dreq(dreq),
    .i_bus_done(done), .o_bus_read(bus_rd), .o_bus_write(bus_wr), .o_dack(dack), .o_irq(irq));
  dma_term_bus_model #(.LAT(1)) dma_term_bus_model_i (.i_clk_sys(clk), .i_nrst(nrst),
    .i_bus_read(bus_rd), .i_bus_write(bus_wr), .o_bus_done(done), .o_nrd(nrd), .o_nwr(nwr));

  always #25 clk = ~clk;
  // level mode holds the request up, edge mode toggles it every four cycles
  always @(posedge clk) begin
    tick <= tick + 4'h1;
    dreq <= ch_sel & {2{req_mode == 2'h1 || (req_mode == 2'h2 && tick[2])}};
    for (int c = 0; c < 2; c++) if (dack[c] === 1'b1) ndack[c]++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rdat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_idle(input int ch);
    repeat (300) begin
      rd(8'(4 * ch));
      if (rdat[`BIT_BUSY] === 1'b0 && rdat[`BIT_RUN] === 1'b0) break;
    end
  endtask
  task automatic s_regs;
    rd(`OFF_CH1_CTRL);
    chk(rdat, `CTRL_RESET);
    rd(`OFF_IRQ_STAT);
    chk(rdat, 32'h0);
    rd(8'h20);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    chk(rdat, 32'h0);
    wr(8'h22, 32'h1);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    wr(`OFF_IRQ_EN, 32'h3);
    chk({30'h0, resp}, {30'h0, `RESP_OKAY});
  endtask
  // run a long count, clear the run bit mid-stream, then watch the channel stay quiet
  task automatic s_halt(input logic [1:0] m, input int ch);
    logic [31:0] base;
    int          d0, w0, r0;
    base = {24'h0, 1'b1, ~m[0], m[1], 5'h0};
    d0 = ndack[ch];
    w0 = nwr[ch];
    r0 = nrd[ch];
    wr(`OFF_CH0_COUNT + 8'(4 * ch), 32'd200);
    ch_sel <= 2'h1 << ch;
    req_mode <= m[0] ? 2'h2 : 2'h1;
    wr(8'(4 * ch), base | 32'h1);
    repeat (400) begin
      @(posedge clk);
      if (ndack[ch] - d0 >= 2) break;
    end
    wr(8'(4 * ch), base);
    wait_idle(ch);
    chk({31'h0, rdat[`BIT_TEND]}, 32'h0);
    chk(nwr[ch] - w0, ndack[ch] - d0);
    chk(nrd[ch] - r0, ndack[ch] - d0);
    chk({31'h0, irq}, 32'h0);
    d0 = ndack[ch];
    repeat (60) @(posedge clk);
    chk(ndack[ch] - d0, 32'h0);
    chk({28'h0, bus_rd, bus_wr}, 32'h0);
  endtask
  // the last mode runs single-address so the one-phase path is counted too
  task automatic s_count(input logic [1:0] m, input int ch, input int n, input logic ie);
    logic [31:0] base;
    logic        dual;
    int          d0, w0, r0;
    dual = (m != 2'h3);
    base = {24'h0, dual, ~m[0], m[1], 5'h0};
    d0 = ndack[ch];
    w0 = nwr[ch];
    r0 = nrd[ch];
    wr(`OFF_CH0_COUNT + 8'(4 * ch), 32'(n));
    wr(8'(4 * ch), base | {29'h0, ie, 2'b01});
    wait_idle(ch);
    chk(ndack[ch] - d0, 32'(n));
    chk(nwr[ch] - w0, dual ? 32'(n) : 32'h0);
    chk(nrd[ch] - r0, 32'(n));
    chk({29'h0, rdat[2:0]}, {29'h0, ie, 2'b10});
    rd(`OFF_CH0_COUNT + 8'(4 * ch));
    chk(rdat, 32'h0);
    rd(`OFF_IRQ_STAT);
    chk({31'h0, rdat[ch]}, 32'h1);
    chk({31'h0, irq}, {31'h0, ie});
    wr(`OFF_IRQ_CLR, 32'h1 << ch);
    rd(`OFF_IRQ_STAT);
    chk({31'h0, rdat[ch]}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    req_mode <= 2'h0;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #(50 * 60000);
    num_errors++;
    $display("[ERR] %0t watchdog ran out", $time);
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    s_regs();
    for (int m = 0; m < 4; m++) begin
      s_halt(2'(m), m % 2);
      s_count(2'(m), m % 2, 3 + m, m < 2);
    end
    end_sim();
  end
endmodule
`default_nettype wire

// ==== verification/dma_term_bus_model.sv ====
// bus phase responder standing in for memory on both channels
`timescale 1ns/1ps
`default_nettype none
module dma_term_bus_model #(
  parameter int LAT = 1
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic [1:0] i_bus_read,
  input  wire logic [1:0] i_bus_write,
  output logic [1:0]      o_bus_done,
  output int              o_nrd [2],
  output int              o_nwr [2]
);
  int wait_cnt [2];
  // channel 1 answers slower so both prompt and stalled phases are seen
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bus_done <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        wait_cnt[c] <= 0;
        o_nrd[c] <= 0;
        o_nwr[c] <= 0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (o_bus_done[c]) begin
          o_bus_done[c] <= 1'b0;
          wait_cnt[c] <= 0;
        end else if (i_bus_read[c] || i_bus_write[c]) begin
          if (wait_cnt[c] >= LAT + 3 * c) begin
            o_bus_done[c] <= 1'b1;
            if (i_bus_read[c]) o_nrd[c] <= o_nrd[c] + 1;
            else o_nwr[c] <= o_nwr[c] + 1;
          end else begin
            wait_cnt[c] <= wait_cnt[c] + 1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire
